/* ajl_axis_ctrl.sv */
// Axis jog, limit interlock, fault check and indicator logic
//
// Design decisions made here: the address-and-strobe port and the address map.
module ajl_axis_ctrl
    import ajl_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_CYC,   // Indicator blink half period
    parameter int ACT_CYCLES   = ACT_CYC      // Link indicator stretch
) (
    input  wire logic                CLK_SYS_I,       // 25 MHz clock
    input  wire logic                SRST_I,          // Sync reset, high
    input  wire logic                LOCAL_I,         // Selector: 1 local
    input  wire logic [NUM_AXES-1:0] JOG_UP_I,        // Jog up switches
    input  wire logic [NUM_AXES-1:0] JOG_DN_I,        // Jog down switches
    input  wire logic [NUM_AXES-1:0] LIM_UP_NC_I,     // Up limit NC contact
    input  wire logic [NUM_AXES-1:0] LIM_UP_NO_I,     // Up limit NO contact
    input  wire logic [NUM_AXES-1:0] LIM_DN_NC_I,     // Down limit NC
    input  wire logic [NUM_AXES-1:0] LIM_DN_NO_I,     // Down limit NO
    input  wire logic                ESTOP_N_I,       // E-stop chain, low=stop
    input  wire logic [NUM_AXES-1:0] OVLD_I,          // Overload aux, 1=trip
    input  wire logic                P2P_CONN_I,      // Point-to-point present
    input  wire logic                LINK_RX_ACT_I,   // Host rx activity
    input  wire logic [NUM_AXES*POS_W-1:0] POS_I,     // Digitized positions
    input  wire logic [7:0]          ADDR_I,          // Register address
    input  wire logic [31:0]         WDATA_I,         // Write data
    input  wire logic                WR_I,            // Write strobe
    input  wire logic                RD_I,            // Read strobe
    output logic      [31:0]         RDATA_O,         // Read data
    output logic      [NUM_AXES-1:0] EN_UP_O,         // Up drive enable
    output logic      [NUM_AXES-1:0] EN_DN_O,         // Down drive enable
    output logic      [NUM_AXES-1:0] ACCEL_O,         // Accelerate command
    output logic      [NUM_AXES-1:0] DECEL_O,         // Decelerate command
    output logic      [NUM_AXES-1:0] LED_UP_O,        // Up indicators
    output logic      [NUM_AXES-1:0] LED_DN_O,        // Down indicators
    output logic                     LED_FAULT_O,     // Fault indicator
    output logic                     LED_LINK_O,      // Link activity LED
    output logic                     MD_PORT_EN_O,    // Multidrop port enable
    output logic                     P2P_PORT_EN_O,   // Point-to-point enable
    output logic      [31:0]         TX_DATA_O,       // Position word to host
    output logic                     TX_VALID_O,      // Position word pulse
    output logic                     IRQ_O            // Level interrupt
);
    localparam int NSYNC = 5 * NUM_AXES + 3;
    // Syncs reset to idle pin levels: no false e-stop or switch fault
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{(2*NUM_AXES){1'b0}},
        {NUM_AXES{1'b1}}, {NUM_AXES{1'b0}}, {NUM_AXES{1'b1}}, 3'b010};

    logic [NSYNC-1:0]      s1;
    logic [NSYNC-1:0]      s2;
    logic [NUM_AXES-1:0]   jup, jdn, lunc, luno, ldnc, ldno, ovld;
    logic                  local_m, estop_n, p2p;
    logic [NUM_AXES*POS_W-1:0] pos_s1, pos;
    logic [31:0]           ctrl;
    logic [NUM_AXES-1:0]   cmd_up, cmd_dn;
    logic [POS_W-1:0]      target [NUM_AXES];
    logic [NUM_AXES-1:0]   fail, at_up, at_dn;
    logic [NUM_AXES-1:0]   req_up, req_dn, next_up, next_dn;
    logic                  estop_latched;
    logic [IRQ_W-1:0]      irq_stat, irq_mask, irq_ev;
    logic [31:0]           blink_cnt, act_cnt;
    logic                  blink;
    logic                  lim_any_d, link_d;
    logic [NUM_AXES-1:0]   feeds_ok;

    // Two-flop sync for jogs, limits except down NO, selector, e-stop, port sense and positions
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            s1     <= SYNC_IDLE;
            s2     <= SYNC_IDLE;
            pos_s1 <= '0;
            pos    <= '0;
        end else begin
            s1     <= {JOG_UP_I, JOG_DN_I, LIM_UP_NC_I, LIM_UP_NO_I,
                       LIM_DN_NC_I, LOCAL_I, ESTOP_N_I, P2P_CONN_I};
            s2     <= s1;
            pos_s1 <= POS_I;
            pos    <= pos_s1;
        end
    end
    assign {jup, jdn, lunc, luno, ldnc, local_m, estop_n, p2p} = s2;

    // Down-limit NO and overloads get their own sync pair
    logic [2*NUM_AXES-1:0] t1, t2;
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            t1 <= '0;
            t2 <= '0;
        end else begin
            t1 <= {LIM_DN_NO_I, OVLD_I};
            t2 <= t1;
        end
    end
    assign {ldno, ovld} = t2;

    // Only az, el and the configured number of feeds may drive
    assign feeds_ok = (ctrl[CTRL_FEEDS_LO +: 2] == 2'd0) ? 4'b0011 :
                      (ctrl[CTRL_FEEDS_LO +: 2] == 2'd1) ? 4'b0111 :
                                                           4'b1111; // [RQ15]

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            logic [POS_W-1:0] p;
            logic             up_near, dn_near;
            assign p = pos[g*POS_W +: POS_W];
            // Contacts must disagree; equal levels mean shorted or open
            assign fail[g]  = (lunc[g] == luno[g]) ||
                              (ldnc[g] == ldno[g]);             // [RQ9]
            // NC contact opens when the limit engages
            assign at_up[g] = !lunc[g] && luno[g];
            assign at_dn[g] = !ldnc[g] && ldno[g];
            assign up_near  = (p < target[g]) &&
                              (target[g] - p > POS_W'(TOL));
            assign dn_near  = (p > target[g]) &&
                              (p - target[g] > POS_W'(TOL));
            always_comb begin
                if (local_m) begin
                    req_up[g] = jup[g];                         // [RQ1] [RQ5]
                    req_dn[g] = jdn[g];
                end else if (ctrl[CTRL_POS_MODE]) begin
                    req_up[g] = cmd_up[g] && up_near;           // [RQ14]
                    req_dn[g] = cmd_dn[g] && dn_near;
                end else begin
                    req_up[g] = cmd_up[g];                      // [RQ6]
                    req_dn[g] = cmd_dn[g];
                end
                next_up[g] = req_up[g] && !req_dn[g] && !at_up[g] &&
                             !fail[g] && !ovld[g] && !estop_latched &&
                             feeds_ok[g];                       // [RQ8] [RQ16]
                next_dn[g] = req_dn[g] && !req_up[g] && !at_dn[g] &&
                             !fail[g] && !ovld[g] && !estop_latched &&
                             feeds_ok[g];                       // [RQ8] [RQ16]
            end
        end
    endgenerate

    // Drive outputs
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            EN_UP_O <= '0;
            EN_DN_O <= '0;
            ACCEL_O <= '0;
            DECEL_O <= '0;
        end else begin
            EN_UP_O <= next_up;
            EN_DN_O <= next_dn;
            // Accelerate pulses one cycle as the enable rises, decelerate one cycle as it drops
            ACCEL_O <= ctrl[CTRL_VSPEED] ?
                       ((next_up | next_dn) & ~(EN_UP_O | EN_DN_O)) :
                       '0;                                      // [RQ7]
            DECEL_O <= ctrl[CTRL_VSPEED] ?
                       ((EN_UP_O | EN_DN_O) & ~(next_up | next_dn)) :
                       '0;                                      // [RQ7]
        end
    end

    // E-stop latches; a chain still open keeps it set despite the clear
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I)
            estop_latched <= 1'b0;
        else if (!estop_n)
            estop_latched <= 1'b1;                              // [RQ10]
        else if (WR_I && ADDR_I == ADDR_CTRL && WDATA_I[CTRL_ESTOP_CLR])
            estop_latched <= 1'b0;                              // [RQ10]
    end

    // Blink timebase
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt <= '0;
            blink     <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 32'd1;
        end
    end

    // Steady while moving, blink at limit, fast-on for failure
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            LED_UP_O <= '0;
            LED_DN_O <= '0;
        end else begin
            LED_UP_O <= fail | next_up | (at_up & {NUM_AXES{blink}}); // [RQ2]
            LED_DN_O <= fail | next_dn | (at_dn & {NUM_AXES{blink}}); // [RQ2]
        end
    end

    // Fault LED and link activity stretch
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            LED_FAULT_O <= 1'b0;
            LED_LINK_O  <= 1'b0;
            act_cnt     <= '0;
        end else begin
            LED_FAULT_O <= (|fail) || (|ovld) || estop_latched;  // [RQ3]
            if (LINK_RX_ACT_I || WR_I && ADDR_I == ADDR_CMD || TX_VALID_O)
                act_cnt <= 32'(ACT_CYCLES);
            else if (act_cnt != 32'd0)
                act_cnt <= act_cnt - 32'd1;
            LED_LINK_O  <= (act_cnt != 32'd0);                   // [RQ4]
        end
    end

    // Port selection
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            MD_PORT_EN_O  <= 1'b0;
            P2P_PORT_EN_O <= 1'b0;
        end else begin
            MD_PORT_EN_O  <= !p2p;                               // [RQ12]
            P2P_PORT_EN_O <= p2p;
        end
    end

    // Position word to host: axis index in bits 17:16 above the position
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            TX_DATA_O  <= '0;
            TX_VALID_O <= 1'b0;
        end else begin
            TX_VALID_O <= WR_I && ADDR_I == ADDR_TX;             // [RQ13]
            if (WR_I && ADDR_I == ADDR_TX)
                TX_DATA_O <= {14'h0, WDATA_I[1:0],
                              pos[WDATA_I[1:0]*POS_W +: POS_W]};  // [RQ13]
        end
    end

    // Control, command and target registers
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            ctrl   <= CTRL_RESET;
            cmd_up <= '0;
            cmd_dn <= '0;
            for (int i = 0; i < NUM_AXES; i++)
                target[i] <= '0;
        end else if (WR_I) begin
            if (ADDR_I == ADDR_CTRL)
                ctrl <= {27'h0, WDATA_I[4:1], 1'b0};
            if (ADDR_I == ADDR_CMD) begin
                cmd_up <= WDATA_I[3:0];                           // [RQ6]
                cmd_dn <= WDATA_I[7:4];
            end
            for (int i = 0; i < NUM_AXES; i++)
                if (ADDR_I == ADDR_TARGET0 + 8'(4 * i))
                    target[i] <= WDATA_I[POS_W-1:0];
        end
    end

    // Interrupts: set wins over write-one-to-clear
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            lim_any_d <= 1'b0;
            link_d    <= 1'b0;
        end else begin
            lim_any_d <= |(at_up | at_dn);
            link_d    <= |fail;
        end
    end
    assign irq_ev[IRQ_FAULT] = (|fail) && !link_d;
    assign irq_ev[IRQ_ESTOP] = !estop_n;
    assign irq_ev[IRQ_LIMIT] = (|(at_up | at_dn)) && !lim_any_d;
    assign irq_ev[IRQ_OVLD]  = |ovld;                            // [RQ11]

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (WR_I && ADDR_I == ADDR_IRQ_MASK)
                irq_mask <= WDATA_I[IRQ_W-1:0];
            if (WR_I && ADDR_I == ADDR_IRQ_STAT)
                irq_stat <= (irq_stat & ~WDATA_I[IRQ_W-1:0]) | irq_ev;
            else
                irq_stat <= irq_stat | irq_ev;
        end
    end
    assign IRQ_O = |(irq_stat & irq_mask);

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            RDATA_O <= 32'h0;
            if (ADDR_I == ADDR_CTRL)
                RDATA_O <= ctrl;
            if (ADDR_I == ADDR_CMD)
                RDATA_O <= {24'h0, cmd_dn, cmd_up};
            if (ADDR_I == ADDR_STATUS)
                RDATA_O <= {8'h0, ovld, fail, at_dn, at_up,
                            5'h0, p2p, local_m, estop_latched};  // [RQ11]
            if (ADDR_I == ADDR_IRQ_STAT)
                RDATA_O <= {28'h0, irq_stat};
            if (ADDR_I == ADDR_IRQ_MASK)
                RDATA_O <= {28'h0, irq_mask};
            for (int i = 0; i < NUM_AXES; i++) begin
                if (ADDR_I == ADDR_TARGET0 + 8'(4 * i))
                    RDATA_O <= {16'h0, target[i]};
                if (ADDR_I == ADDR_POS0 + 8'(4 * i))
                    RDATA_O <= {16'h0, pos[i*POS_W +: POS_W]};  // [RQ13]
            end
        end else begin
            RDATA_O <= '0;
        end
    end

    // Checks
    property p_no_both;
        @(posedge CLK_SYS_I) disable iff (SRST_I) !(|(EN_UP_O & EN_DN_O));
    endproperty
    a_no_both: assert property (p_no_both) // [RQ16]
        else $error("up and down both");
    property p_limit_blocks;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (|at_up) |=> !(|(EN_UP_O & $past(at_up)));
    endproperty
    a_limit_blocks: assert property (p_limit_blocks) // [RQ8]
        else $error("drive into limit");
    property p_estop;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !estop_n |=> ##1 (EN_UP_O == '0 && EN_DN_O == '0);
    endproperty
    a_estop: assert property (p_estop) // [RQ10]
        else $error("moving in e-stop");
    property p_fault_led;
        @(posedge CLK_SYS_I) disable iff (SRST_I) (|fail) |=> LED_FAULT_O;
    endproperty
    a_fault_led: assert property (p_fault_led) // [RQ3]
        else $error("fault led off");
    property p_port;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        p2p |=> !MD_PORT_EN_O;
    endproperty
    a_port: assert property (p_port) // [RQ12]
        else $error("multidrop active");
    property p_remote_jog;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (!local_m && cmd_up == '0 && cmd_dn == '0) |=> EN_UP_O == '0;
    endproperty
    a_remote_jog: assert property (p_remote_jog) // [RQ1]
        else $error("jog in remote");
    property p_fail_stop;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (|fail) |=> !(|((EN_UP_O | EN_DN_O) & $past(fail)));
    endproperty
    a_fail_stop: assert property (p_fail_stop) // [RQ9]
        else $error("drive on failed switch");
    property p_link_led;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        LINK_RX_ACT_I |=> ##1 LED_LINK_O;
    endproperty
    a_link_led: assert property (p_link_led) // [RQ4]
        else $error("link led off");
    property p_feed_limit;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !(|((EN_UP_O | EN_DN_O) & ~$past(feeds_ok)));
    endproperty
    a_feed_limit: assert property (p_feed_limit) // [RQ15]
        else $error("unconfigured feed driven");
    property p_accel_vspeed;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (|(ACCEL_O | DECEL_O)) |-> $past(ctrl[CTRL_VSPEED]);
    endproperty
    a_accel_vspeed: assert property (p_accel_vspeed) // [RQ7]
        else $error("ramp command without variable speed");
    c_move: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
        |EN_UP_O);
    c_estop: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
        estop_latched ##1 !estop_latched);
    c_irq: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I) IRQ_O);
    c_pos_mode: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
        ctrl[CTRL_POS_MODE] && (|EN_UP_O));
    c_accel: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
        |ACCEL_O);
endmodule : ajl_axis_ctrl

/* ajl_host_model.sv */
// Behavioural host tracking controller facing the axis control block
module ajl_host_model (
    input  wire logic        clk_i,        // System clock
    input  wire logic        srst_i,       // Sync reset, high
    input  wire logic        send_i,       // Bench asks for host traffic
    input  wire logic [31:0] tx_data_i,    // Position word from device
    input  wire logic        tx_valid_i,   // Position word strobe
    output logic             link_act_o,   // Host receive activity
    output logic      [31:0] last_word_o,  // Last position word seen
    output logic      [7:0]  n_words_o     // Words received
);
    // Host traffic marks the link busy one cycle later for each cycle send_i is high
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            link_act_o <= 1'b0;
        end else begin
            link_act_o <= send_i;
        end
    end

    // Words are taken only on the device's strobe, never from idle data
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            last_word_o <= 32'h0000_0000;
            n_words_o   <= 8'h00;
        end else if (tx_valid_i) begin
            last_word_o <= tx_data_i;
            n_words_o   <= n_words_o + 8'h01;
        end
    end
endmodule // ajl_host_model

/* ajl_pkg.sv */
// Package: constants and register map for the antenna axis control
// What this block does
// [RQ1] Jog switches act only in local mode
// [RQ2] Up/down indicators: steady motion, blink fault/limit; the code lights a switch failure steady
// [RQ3] Fault indicator lights on any detected failure
// [RQ4] Link indicator lights while host traffic runs
// [RQ5] Local jogs become per-axis up/down enables
// [RQ6] Remote host commands drive the enables
// [RQ7] Variable speed adds accelerate/decelerate outputs
// [RQ8] Limit blocks only its own direction
// [RQ9] Equal limit contact levels flag switch failure
// [RQ10] Emergency stop halts until manual reset
// [RQ11] Overload relay contacts read as status
// [RQ12] Point-to-point port disables multidrop port
// [RQ13] Position data sent over active port
// [RQ14] Position feedback decides drive and stop
// [RQ15] At most two feed axes beside az/el
// [RQ16] Never drive up and down together
package ajl_pkg;
    localparam int          NUM_AXES        = 4;
    localparam int          POS_W           = 16;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_CMD        = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
    localparam logic [7:0]  ADDR_TARGET0    = 8'h20;
    localparam logic [7:0]  ADDR_POS0       = 8'h40;
    localparam logic [7:0]  ADDR_TX         = 8'h60;
    localparam int          CTRL_ESTOP_CLR  = 0;
    localparam int          CTRL_VSPEED     = 1;
    localparam int          CTRL_FEEDS_LO   = 2;
    localparam int          CTRL_POS_MODE   = 4;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_000C;
    localparam int          IRQ_W           = 4;
    localparam int          IRQ_FAULT       = 0;
    localparam int          IRQ_ESTOP       = 1;
    localparam int          IRQ_LIMIT       = 2;
    localparam int          IRQ_OVLD        = 3;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          BLINK_MS        = 250;
    localparam int          BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
    localparam int          ACT_MS          = 50;
    localparam int          ACT_CYC         = CLK_HZ / 1000 * ACT_MS;
    localparam int          TOL             = 4;
endpackage : ajl_pkg

/* tb_ajl_axis_ctrl.sv */
// Self-checking bench for the antenna axis control block
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_ajl_axis_ctrl;
    import ajl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS_I, SRST_I, LOCAL_I, ESTOP_N_I, P2P_CONN_I, WR_I, RD_I;
    logic [3:0] JOG_UP_I, JOG_DN_I, OVLD_I, LIM_UP_NC_I, LIM_UP_NO_I;
    logic [3:0] LIM_DN_NC_I, LIM_DN_NO_I, EN_UP_O, EN_DN_O, ACCEL_O, DECEL_O;
    logic [3:0] LED_UP_O, LED_DN_O, lu, ld, ju, jd;
    logic LED_FAULT_O, LED_LINK_O, MD_PORT_EN_O, P2P_PORT_EN_O, IRQ_O;
    logic LINK_RX_ACT_I, TX_VALID_O, send, seen;
    logic [63:0] POS_I;
    logic [7:0]  ADDR_I, n_words;
    logic [31:0] WDATA_I, RDATA_O, TX_DATA_O, d, last_word;
    logic [1:0]  ax;
    int err_count = 0, n_checks = 0, cyc = 0;

    ajl_axis_ctrl #(.BLINK_CYCLES(4), .ACT_CYCLES(8)) ajl_axis_ctrl_i (.*);
    ajl_host_model ajl_host_model_i (.clk_i(CLK_SYS_I), .srst_i(SRST_I),
        .send_i(send), .tx_data_i(TX_DATA_O), .tx_valid_i(TX_VALID_O),
        .link_act_o(LINK_RX_ACT_I), .last_word_o(last_word),
        .n_words_o(n_words));

    initial begin
        CLK_SYS_I = 1'b0;
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge CLK_SYS_I) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS_I);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK_SYS_I);
        ADDR_I  <= a;
        WDATA_I <= v;
        WR_I    <= 1'b1;
        @(posedge CLK_SYS_I);
        WR_I    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK_SYS_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge CLK_SYS_I);
        RD_I   <= 1'b0;
        #1 v = RDATA_O;
    endtask

    // Engaged switch opens NC and closes NO
    task automatic set_lim(input logic [3:0] u, input logic [3:0] n);
        LIM_UP_NC_I <= ~u;
        LIM_UP_NO_I <= u;
        LIM_DN_NC_I <= ~n;
        LIM_DN_NO_I <= n;
    endtask

    // Settle time covers two sync flops and the output register
    task automatic settle();
        tick(5);
        #1;
    endtask

    function automatic logic [3:0] exp_en(input logic [3:0] a, b, l);
        return a & ~b & ~l;
    endfunction

    initial begin
        void'($urandom(91474));
        {SRST_I, LOCAL_I, ESTOP_N_I} = 3'b111;
        {P2P_CONN_I, WR_I, RD_I, send} = 4'h0;
        {JOG_UP_I, JOG_DN_I, OVLD_I} = 12'h000;
        {LIM_UP_NC_I, LIM_UP_NO_I, LIM_DN_NC_I, LIM_DN_NO_I} = 16'hF0F0;
        POS_I = 64'h0;
        ADDR_I = 8'h00;
        WDATA_I = 32'h0;
        tick(5);
        SRST_I <= 1'b0;
        tick(4);
        rd(ADDR_CTRL, d);
        `CHK(d, CTRL_RESET)
        rd(8'hFC, d);
        `CHK(d, 32'h0000_0000)
        `CHK({MD_PORT_EN_O, P2P_PORT_EN_O}, 2'b10)
        P2P_CONN_I <= 1'b1;
        settle();
        `CHK({MD_PORT_EN_O, P2P_PORT_EN_O}, 2'b01)
        P2P_CONN_I <= 1'b0;
        $display("test registers and ports done");

        for (int i = 0; i < 24; i++) begin
            ju = 4'($urandom);
            jd = (i < 4) ? ju : 4'($urandom);
            lu = 4'($urandom);
            ld = 4'($urandom);
            JOG_UP_I <= ju;
            JOG_DN_I <= jd;
            set_lim(lu, ld);
            settle();
            `CHK(EN_UP_O, exp_en(ju, jd, lu))
            `CHK(EN_DN_O, exp_en(jd, ju, ld))
        end
        rd(ADDR_STATUS, d);
        `CHK(d[15:8], {ld, lu})
        set_lim(4'h5, 4'h0);
        settle();
        ju = 4'h0;
        jd = 4'hF;
        repeat (8) begin
            tick(1);
            #1 ju |= LED_UP_O;
            jd &= LED_UP_O;
        end
        `CHK(ju & 4'h5, 4'h5)
        `CHK(jd & 4'h5, 4'h0)
        set_lim(4'h0, 4'h0);
        $display("test local jog done");

        JOG_UP_I <= 4'hF;
        JOG_DN_I <= 4'h0;
        LOCAL_I  <= 1'b0;
        settle();
        `CHK(EN_UP_O, 4'h0)
        wr(ADDR_CMD, 32'h0000_0021);
        settle();
        `CHK({EN_UP_O, EN_DN_O}, 8'h12)
        `CHK(LED_DN_O, 4'h2)
        wr(ADDR_CMD, 32'h0000_0011);
        settle();
        `CHK({EN_UP_O, EN_DN_O}, 8'h00)
        wr(ADDR_CMD, 32'h0000_0000);
        JOG_UP_I <= 4'h0;
        LOCAL_I  <= 1'b1;
        $display("test remote done");

        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        LIM_UP_NO_I <= 4'h4;
        settle();
        `CHK({LED_FAULT_O, IRQ_O}, 2'b11)
        `CHK({LED_UP_O[2], LED_DN_O[2]}, 2'b11)
        rd(ADDR_STATUS, d);
        `CHK(d[19:16], 4'h4)
        LIM_UP_NO_I <= 4'h0;
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        #1 `CHK(IRQ_O, 1'b0)
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        #1 `CHK(IRQ_O, 1'b1)
        wr(ADDR_IRQ_STAT, 32'h0000_0001);
        #1 `CHK(IRQ_O, 1'b0)
        OVLD_I   <= 4'h9;
        JOG_UP_I <= 4'hF;
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d[23:20], 4'h9)
        `CHK(EN_UP_O, 4'h6)
        OVLD_I <= 4'h0;
        $display("test faults done");

        ESTOP_N_I <= 1'b0;
        JOG_UP_I  <= 4'h1;
        settle();
        `CHK(EN_UP_O, 4'h0)
        ESTOP_N_I <= 1'b1;
        settle();
        `CHK(EN_UP_O, 4'h0)
        wr(ADDR_CTRL, 32'h0000_000D);
        settle();
        `CHK(EN_UP_O, 4'h1)
        `CHK(LED_UP_O[0], 1'b1)
        JOG_UP_I <= 4'hF;
        wr(ADDR_CTRL, 32'h0000_0004);
        settle();
        `CHK(EN_UP_O, 4'h7)
        JOG_UP_I <= 4'h0;
        $display("test emergency stop done");

        wr(ADDR_CTRL, 32'h0000_000E);
        tick(2);
        JOG_UP_I <= 4'h1;
        seen = 1'b0;
        repeat (8) begin
            tick(1);
            #1 seen |= ACCEL_O[0];
        end
        `CHK(seen, 1'b1)
        JOG_UP_I <= 4'h0;
        seen = 1'b0;
        repeat (8) begin
            tick(1);
            #1 seen |= DECEL_O[0];
        end
        `CHK(seen, 1'b1)
        wr(ADDR_CTRL, 32'h0000_000C);
        $display("test variable speed done");

        LOCAL_I <= 1'b0;
        POS_I   <= {48'h0, 16'h0100 - 16'(TOL) - 16'h0001};
        wr(ADDR_TARGET0, 32'h0000_0100);
        wr(ADDR_CTRL, 32'h0000_001C);
        wr(ADDR_CMD, 32'h0000_0001);
        settle();
        `CHK(EN_UP_O, 4'h1)
        POS_I   <= {48'h0, 16'h0100 - 16'(TOL)};
        settle();
        `CHK(EN_UP_O, 4'h0)
        rd(ADDR_TARGET0, d);
        `CHK(d, 32'h0000_0100)
        wr(ADDR_CMD, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_000C);
        LOCAL_I <= 1'b1;
        $display("test position mode done");

        POS_I <= {$urandom, $urandom};
        ax = 2'($urandom);
        tick(4);
        wr(ADDR_TX, {30'h0, ax});
        #1 `CHK(TX_VALID_O, 1'b1)
        tick(2);
        `CHK(last_word, {14'h0, ax, POS_I[ax*16 +: 16]})
        `CHK(n_words, 8'h01)
        send <= 1'b1;
        tick(1);
        send <= 1'b0;
        tick(3);
        #1 `CHK(LED_LINK_O, 1'b1)
        tick(20);
        #1 `CHK(LED_LINK_O, 1'b0)
        $display("test host link done");
        tally_and_finish();
    end
endmodule // tb_ajl_axis_ctrl
